//--- design/cfgl_cfg.svh
`ifndef CFGL_CFG_SVH
`define CFGL_CFG_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define CFGL_CLK_MHZ 50
`define CFGL_RST_NS 200
`define CFGL_RST_CYC ((`CFGL_RST_NS * `CFGL_CLK_MHZ + 999) / 1000)
`define CFGL_CLR_US 300
`define CFGL_CLR_CYC (`CFGL_CLR_US * `CFGL_CLK_MHZ)
`define CFGL_DONE_WAIT 64
`define CFGL_DUMMY_BITS 49
`define CFGL_SYNC_WORD 32'h7EAA997E

// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define CFGL_REG_CTRL 8'h00
`define CFGL_REG_STAT 8'h04
`define CFGL_REG_DATA 8'h08
`define CFGL_REG_DIV 8'h0C
`define CFGL_CTRL_START 0
`define CFGL_CTRL_LAST 1
`define CFGL_DIV_RST 5'h02
`define CFGL_DIV_MIN 5'h01
`define CFGL_DIV_MAX 5'h19
`define CFGL_RESP_OKAY 2'h0
`define CFGL_RESP_SLVERR 2'h2

`endif

//--- design/cfgl_pkg.sv
package cfgl_pkg;
   // ----------------------------------------
   // loader sequence states
   // ----------------------------------------
   typedef enum logic [2:0] {
      CFGL_IDLE   = 3'b000,
      CFGL_RESET  = 3'b001,
      CFGL_CLEAR  = 3'b010,
      CFGL_STREAM = 3'b011,
      CFGL_CHECK  = 3'b100,
      CFGL_DUMMY  = 3'b101,
      CFGL_LOADED = 3'b110,
      CFGL_FAILED = 3'b111
   } cfgl_state_t;
endpackage

//--- design/cfgl_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cfgl_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // levels from outside the clock domain
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   // two stages; the first is read by the second only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

//--- design/cfgl_tick.sv
`timescale 1ns/1ps
`default_nettype none
module cfgl_tick (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   input wire logic run,
   input wire logic [4:0] half_div,
   // one-cycle enable every half_div cycles
   output logic tick
);
   logic [4:0] cnt_r;

   // divider restarts whenever run drops, so phases start clean
   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         cnt_r <= 5'h00;
         tick <= 1'b0;
      end else if (cnt_r >= half_div - 5'h01) begin
         cnt_r <= 5'h00;
         tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 5'h01;
         tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- design/cfgl_host.sv
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cfgl_cfg.svh"
// Operation
// - host drives reset low with select low for at least 200 ns
// - after reset rises host waits at least 300 us before data
// - image sent this way has no cold or warm boot options
// - whole image goes as one continuous stream without gaps; here a word that arrives late leaves a gap, flagged as underrun
// - after the sync word serial clock stays within 1 to 25 MHz
// - each byte goes most significant bit first
// - host changes serial data on falling clock edges
// - done still low after the image means failure for the host
// - after done is high host sends at least 49 dummy clocks
// - pulsing reset low restarts the whole configuration
module cfgl_host #(
   parameter int CLR_CYC = `CFGL_CLR_CYC,
   parameter int DONE_WAIT = `CFGL_DONE_WAIT
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // open-drain configuration reset
   input wire logic config_reset_n_i,
   output logic config_reset_n_o,
   output logic config_reset_n_oe,
   // serial port towards the device
   output logic spi_select_n,
   output logic spi_clk,
   output logic spi_data,
   // done from the device
   input wire logic config_done
);
   import cfgl_pkg::*;

   localparam int RST_CYC_I = `CFGL_RST_CYC;
   localparam int DUMMY_I = `CFGL_DUMMY_BITS;

   cfgl_state_t state_r;
   logic [23:0] cnt_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic aw_full_r, w_full_r, last_r, underrun_r, started_r;
   logic [31:0] pend_r, sh_r;
   logic pend_full_r, word_act_r;
   logic [4:0] bit_cnt_r, div_r;
   logic [5:0] dcnt_r;
   logic done_s, creset_s, tick;
   logic do_write, start_cmd, load_now, rise_now, fall_now, wrap, take;
   logic [7:0] wsel, rsel;

   // ----------------------------------------
   // pin synchronisers and clock divider
   // ----------------------------------------
   cfgl_sync #(.W(2)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({config_done, config_reset_n_i}),
      .q({done_s, creset_s})
   );

   cfgl_tick u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(state_r == CFGL_STREAM || state_r == CFGL_DUMMY),
      .half_div(div_r),
      .tick(tick)
   );

   // ----------------------------------------
   // decode of bus and shifter events
   // ----------------------------------------
   assign do_write = aw_full_r && w_full_r && !bvalid;
   assign wsel = {aw_addr_r[7:2], 2'b00};
   assign rsel = {araddr[7:2], 2'b00};
   assign start_cmd = do_write && wsel == `CFGL_REG_CTRL && w_data_r[`CFGL_CTRL_START];
   assign load_now = state_r == CFGL_STREAM && !word_act_r && !spi_clk && pend_full_r;
   // device samples on the rising edge, so rise only with a bit on the line
   assign rise_now = tick && !spi_clk && (state_r == CFGL_DUMMY || word_act_r);
   assign fall_now = tick && spi_clk;
   assign wrap = fall_now && state_r == CFGL_STREAM && bit_cnt_r == 5'h1F;
   assign take = load_now || (wrap && pend_full_r);

   // ----------------------------------------
   // axi4-lite write channel
   // ----------------------------------------
   // address and data are latched apart, so either may come first
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         awready <= 1'b1;
         wready <= 1'b1;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h00000000;
         bvalid <= 1'b0;
         bresp <= `CFGL_RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_addr_r <= awaddr;
            aw_full_r <= 1'b1;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            w_data_r <= wdata;
            w_full_r <= 1'b1;
            wready <= 1'b0;
         end
         if (do_write) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid <= 1'b1;
            // a data word with the holding register full is refused
            if (wsel == `CFGL_REG_CTRL || wsel == `CFGL_REG_DIV
                  || (wsel == `CFGL_REG_DATA && !pend_full_r)) begin
               bresp <= `CFGL_RESP_OKAY;
            end else begin
               bresp <= `CFGL_RESP_SLVERR;
            end
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   // divider is clamped so the serial clock stays inside 1..25 MHz
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_r <= `CFGL_DIV_RST;
      end else if (do_write && wsel == `CFGL_REG_DIV && wstrb[0]) begin
         if (w_data_r[4:0] < `CFGL_DIV_MIN) begin
            div_r <= `CFGL_DIV_MIN;
         end else if (w_data_r[4:0] > `CFGL_DIV_MAX) begin
            div_r <= `CFGL_DIV_MAX;
         end else begin
            div_r <= w_data_r[4:0];
         end
      end
   end

   // end-of-image mark; a fresh start forgets it
   always_ff @(posedge aclk) begin
      if (!aresetn || start_cmd) begin
         last_r <= 1'b0;
      end else if (do_write && wsel == `CFGL_REG_CTRL && w_data_r[`CFGL_CTRL_LAST]) begin
         last_r <= 1'b1;
      end
   end

   // one-word holding register; take beats a same-cycle bus write
   always_ff @(posedge aclk) begin
      if (!aresetn || start_cmd) begin
         pend_full_r <= 1'b0;
         pend_r <= 32'h00000000;
      end else if (take) begin
         pend_full_r <= 1'b0;
      end else if (do_write && wsel == `CFGL_REG_DATA && !pend_full_r) begin
         pend_r <= w_data_r; // words pass unaltered, boot options are the image's
         pend_full_r <= 1'b1;
      end
   end

   // ----------------------------------------
   // axi4-lite read channel
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `CFGL_RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rresp <= `CFGL_RESP_OKAY;
         case (rsel)
            `CFGL_REG_CTRL: rdata <= {30'h00000000, last_r, 1'b0};
            `CFGL_REG_STAT: rdata <= {23'h000000, state_r == CFGL_FAILED,
               state_r == CFGL_LOADED, underrun_r, creset_s, done_s,
               pend_full_r, state_r};
            `CFGL_REG_DATA: rdata <= pend_r;
            `CFGL_REG_DIV: rdata <= {27'h0000000, div_r};
            default: begin
               rdata <= 32'h00000000;
               rresp <= `CFGL_RESP_SLVERR;
            end
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // ----------------------------------------
   // configuration sequence
   // ----------------------------------------
   // start is honoured in every state, so a reset pulse always restarts
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= CFGL_IDLE;
         cnt_r <= 24'h000000;
         config_reset_n_o <= 1'b0;
         config_reset_n_oe <= 1'b1;
         spi_select_n <= 1'b1;
      end else if (start_cmd) begin
         state_r <= CFGL_RESET;
         cnt_r <= 24'h000000;
         config_reset_n_oe <= 1'b0;
         spi_select_n <= 1'b0;
      end else begin
         case (state_r)
            CFGL_RESET: begin
               cnt_r <= cnt_r + 24'h000001;
               if (cnt_r == 24'(RST_CYC_I - 1)) begin
                  state_r <= CFGL_CLEAR;
                  cnt_r <= 24'h000000;
                  config_reset_n_oe <= 1'b1;
               end
            end
            CFGL_CLEAR: begin
               // wait is counted only once the pin has really gone high
               if (creset_s) begin
                  cnt_r <= cnt_r + 24'h000001;
                  if (cnt_r == 24'(CLR_CYC - 1)) begin
                     state_r <= CFGL_STREAM;
                     cnt_r <= 24'h000000;
                  end
               end
            end
            CFGL_STREAM: begin
               if (!word_act_r && !pend_full_r && last_r && !spi_clk) begin
                  state_r <= CFGL_CHECK;
               end
            end
            CFGL_CHECK: begin
               cnt_r <= cnt_r + 24'h000001;
               if (done_s) begin
                  state_r <= CFGL_DUMMY;
               end else if (cnt_r == 24'(DONE_WAIT - 1)) begin
                  state_r <= CFGL_FAILED;
               end
            end
            CFGL_DUMMY: begin
               if (fall_now && dcnt_r == 6'(DUMMY_I)) begin
                  state_r <= CFGL_LOADED;
                  spi_select_n <= 1'b1;
               end
            end
            CFGL_FAILED: spi_select_n <= 1'b1;
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // serial shifter
   // ----------------------------------------
   // data moves only as the clock falls or while it rests low
   always_ff @(posedge aclk) begin
      if (!aresetn || start_cmd) begin
         spi_clk <= 1'b0;
         spi_data <= 1'b0;
         sh_r <= 32'h00000000;
         bit_cnt_r <= 5'h00;
         word_act_r <= 1'b0;
         dcnt_r <= 6'h00;
      end else begin
         if (rise_now) begin
            spi_clk <= 1'b1;
            if (state_r == CFGL_DUMMY) begin
               dcnt_r <= dcnt_r + 6'h01;
            end
         end else if (fall_now) begin
            spi_clk <= 1'b0;
            if (state_r == CFGL_DUMMY) begin
               spi_data <= 1'b0;
            end else if (wrap) begin
               bit_cnt_r <= 5'h00;
               // next word follows back to back to keep the stream unbroken
               if (pend_full_r) begin
                  sh_r <= pend_r;
                  spi_data <= pend_r[31];
               end else begin
                  word_act_r <= 1'b0;
               end
            end else begin
               sh_r <= {sh_r[30:0], 1'b0};
               spi_data <= sh_r[30];
               bit_cnt_r <= bit_cnt_r + 5'h01;
            end
         end else if (load_now) begin
            sh_r <= pend_r;
            spi_data <= pend_r[31];
            word_act_r <= 1'b1;
         end
      end
   end

   // a word that arrives late leaves a gap; software must know
   always_ff @(posedge aclk) begin
      if (!aresetn || start_cmd) begin
         started_r <= 1'b0;
         underrun_r <= 1'b0;
      end else begin
         if (load_now) begin
            started_r <= 1'b1;
         end
         if (state_r == CFGL_STREAM && started_r && !word_act_r && !pend_full_r
               && !last_r) begin
            underrun_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [7:0] low_cnt_r;
   logic [4:0] phase_cnt_r;

   always_ff @(posedge aclk) begin
      if (!aresetn || config_reset_n_oe) begin
         low_cnt_r <= 8'h00;
      end else if (low_cnt_r != 8'hFF) begin
         low_cnt_r <= low_cnt_r + 8'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || spi_clk != $past(spi_clk)) begin
         phase_cnt_r <= 5'h01;
      end else if (phase_cnt_r != 5'h1F) begin
         phase_cnt_r <= phase_cnt_r + 5'h01;
      end
   end

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_reset_hold: assert property (
      $rose(config_reset_n_oe) |-> low_cnt_r >= 8'(RST_CYC_I))
      else $error("reset released too early");
   a_select_low: assert property (
      !config_reset_n_oe |-> !spi_select_n && !config_reset_n_o)
      else $error("select not low during reset");
   a_clear_wait: assert property (
      (state_r == CFGL_CLEAR ##1 state_r == CFGL_STREAM) |-> $past(cnt_r) == 24'(CLR_CYC - 1))
      else $error("data phase began before clear wait");
   a_clk_high: assert property (
      $fell(spi_clk) |-> phase_cnt_r == $past(div_r))
      else $error("clock high phase not the divider value");
   a_msb_first: assert property (
      load_now |=> spi_data == $past(pend_r[31]) && !spi_clk)
      else $error("first bit is not the word msb");
   a_data_stable: assert property (
      spi_clk && $past(spi_clk) |-> $stable(spi_data))
      else $error("data changed while clock high");
   a_fail_nodone: assert property (
      state_r == CFGL_CHECK && !done_s && cnt_r == 24'(DONE_WAIT - 1) |=> state_r == CFGL_FAILED)
      else $error("missing done not reported");
   a_dummy_count: assert property (
      state_r == CFGL_DUMMY ##1 state_r == CFGL_LOADED |-> $past(dcnt_r) == 6'(DUMMY_I))
      else $error("wrong number of dummy clocks");
   a_restart: assert property (
      start_cmd |=> state_r == CFGL_RESET && !config_reset_n_oe && !spi_clk)
      else $error("start did not restart");

   c_loaded: cover property (state_r == CFGL_DUMMY ##1 state_r == CFGL_LOADED);
   c_failed: cover property (state_r == CFGL_CHECK ##1 state_r == CFGL_FAILED);
   c_back_to_back: cover property (wrap && pend_full_r);
   c_underrun: cover property ($rose(underrun_r));
endmodule
`default_nettype wire

//--- bench/cfgl_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfgl_cfg.svh"
// ----------------------------------------
// behavioural device on the serial port
// ----------------------------------------
// no serial output pin: unused while loading this way
module cfgl_dev_model #(
   parameter int IMG_WORDS = 6,
   parameter real CLR_NS = 1000.0
) (
   // configuration control
   input wire logic config_reset_n,
   input wire logic bad_image,
   output var logic config_done,
   // serial port from the host
   input wire logic spi_select_n,
   input wire logic spi_clk,
   input wire logic spi_data,
   // observation
   output var logic user_io,
   output var logic [7:0] proto_err
);
   logic periph_r = 1'b0;
   logic synced_r = 1'b0;
   logic seen_r = 1'b0;
   logic [31:0] shift_r = '0;
   logic [31:0] rx_words [0:15];
   int bit_cnt = 0;
   int word_cnt = 0;
   int dummy_cnt = 0;
   realtime t_low = -1.0;
   realtime t_high = 0.0;
   realtime t_rise = 0.0;
   realtime t_data = 0.0;

   initial begin
      config_done = 1'b0;
      user_io = 1'b0;
      proto_err = '0;
   end

   // a reset pulse throws away everything received so far
   always @(negedge config_reset_n) begin
      t_low = $realtime;
      periph_r = 1'b0;
      synced_r = 1'b0;
      seen_r = 1'b0;
      config_done = 1'b0;
      user_io = 1'b0;
      bit_cnt = 0;
      word_cnt = 0;
      dummy_cnt = 0;
   end

   // mode is chosen from select at the moment reset rises
   always @(posedge config_reset_n) begin
      if (t_low >= 0.0 && ($realtime - t_low < 200.0 || spi_select_n)) begin
         proto_err = proto_err + 8'h01;
      end
      periph_r = !spi_select_n;
      // select high would mean self-load with reselect, reload and sync retry; not modelled
      t_high = $realtime;
   end

   // data edge time, so the clock processes can judge it without races
   always @(spi_data) t_data = $realtime;

   // capture on the rising clock, msb first, 32-bit sync search
   always @(posedge spi_clk) begin
      if (periph_r && !spi_select_n) begin
         if (!seen_r && $realtime - t_high < CLR_NS) begin
            proto_err = proto_err + 8'h01;
         end
         if (synced_r && !config_done && ($realtime - t_rise > 1000.0 ||
               $realtime - t_rise < 40.0 || t_data == $realtime)) begin
            proto_err = proto_err + 8'h01;
         end
         t_rise = $realtime;
         seen_r = 1'b1;
         shift_r = {shift_r[30:0], spi_data};
         if (config_done) begin
            dummy_cnt++;
         end else if (!synced_r) begin
            synced_r = (shift_r == `CFGL_SYNC_WORD);
         end else begin
            bit_cnt++;
            if (bit_cnt % 32 == 0 && word_cnt < 16) begin
               rx_words[word_cnt] = shift_r;
               word_cnt++;
               // a broken image never lets done float high
               if (word_cnt == IMG_WORDS && !bad_image) config_done = 1'b1;
            end
         end
      end
   end

   // data moving while the clock is high is a host fault
   always @(negedge spi_clk) begin
      if (periph_r && !spi_select_n && t_data > t_rise && t_data < $realtime) begin
         proto_err = proto_err + 8'h01;
      end
   end

   // pins go to the user design only after the dummy clocks
   always @(posedge spi_select_n) begin
      if (config_done && dummy_cnt >= 49) user_io = 1'b1;
   end
endmodule
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfgl_cfg.svh"
module tb;
   import cfgl_pkg::*;
   typedef struct {logic [1:0] resp; logic [31:0] data; logic [31:0] mask;} cfgl_exp_t;
   localparam int CLR = 50;
   logic aclk, aresetn = 1'b0;
   logic [7:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata = '0, rdata, v;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] bresp, rresp;
   logic rst_o, rst_oe, rst_wire, sel_n, sclk, sdata, done, bad_image = 1'b0, user_io;
   logic [7:0] proto_err;
   logic [31:0] img [0:6];
   logic [1:0] wq [$];
   cfgl_exp_t rq [$];
   int err_count = 0, checks = 0, i, d, seed;

   // open-drain reset wire with its pull-up
   assign rst_wire = (rst_oe === 1'b0) ? rst_o : 1'b1;

   cfgl_host #(.CLR_CYC(CLR), .DONE_WAIT(8)) DUT (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .config_reset_n_i(rst_wire),
      .config_reset_n_o(rst_o), .config_reset_n_oe(rst_oe), .spi_select_n(sel_n),
      .spi_clk(sclk), .spi_data(sdata), .config_done(done));
   cfgl_dev_model #(.IMG_WORDS(6), .CLR_NS(CLR * 20.0)) dev (.config_reset_n(rst_wire),
      .bad_image(bad_image), .config_done(done), .spi_select_n(sel_n), .spi_clk(sclk),
      .spi_data(sdata), .user_io(user_io), .proto_err(proto_err));

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   // ----------------------------------------
   // comparison and verdict
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // responses are judged against the oldest note when they appear
   always @(posedge aclk) begin
      if (bvalid === 1'b1 && bready && wq.size() > 0) chk(32'(bresp), 32'(wq.pop_front()));
      if (rvalid === 1'b1 && rready && rq.size() > 0) begin
         chk(32'(rresp), 32'(rq[0].resp));
         chk(rdata & rq[0].mask, rq[0].data & rq[0].mask);
         void'(rq.pop_front());
      end
   end

   // ----------------------------------------
   // bus master tasks, entered right after an edge
   // ----------------------------------------
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
      wq.push_back(er);
      awaddr <= a;
      wdata <= dat;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // no cycle count is assumed; only the watchdog ends a hung wait
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
         input logic [1:0] er, output logic [31:0] got);
      cfgl_exp_t e;
      e.resp = er;
      e.data = exp;
      e.mask = m;
      rq.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         got = rdata;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic wait_state(input logic [2:0] st);
      logic [31:0] s;
      int n;
      n = 0;
      do begin
         axi_rd(`CFGL_REG_STAT, 32'h0, 32'h0, `CFGL_RESP_OKAY, s);
         n++;
      end while (s[2:0] !== st && n < 3000);
      chk(32'(s[2:0]), 32'(st));
   endtask

   // whole load: start, one early word, refused overfill, stream, last
   task automatic load(input logic bad);
      logic [31:0] s;
      int k, n;
      bad_image <= bad;
      axi_wr(`CFGL_REG_CTRL, 32'h1, `CFGL_RESP_OKAY);
      axi_wr(`CFGL_REG_DATA, img[0], `CFGL_RESP_OKAY);
      axi_wr(`CFGL_REG_DATA, img[1], `CFGL_RESP_SLVERR);
      for (k = 1; k < 7; k++) begin
         s = 32'h8;
         n = 0;
         while (s[3] !== 1'b0 && n < 1000) begin
            axi_rd(`CFGL_REG_STAT, 32'h0, 32'h0, `CFGL_RESP_OKAY, s);
            n++;
         end
         axi_wr(`CFGL_REG_DATA, img[k], `CFGL_RESP_OKAY);
      end
      axi_wr(`CFGL_REG_CTRL, 32'h2, `CFGL_RESP_OKAY);
      wait_state(bad ? CFGL_FAILED : CFGL_LOADED);
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      seed = 32'h275422D0;
      // image is sync word then plain data, no boot options in it
      img[0] = `CFGL_SYNC_WORD;
      for (i = 1; i < 7; i++) img[i] = $random(seed);
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_rd(`CFGL_REG_DIV, 32'h2, 32'hFFFFFFFF, `CFGL_RESP_OKAY, v);
      axi_rd(`CFGL_REG_STAT, 32'h20, 32'h1FF, `CFGL_RESP_OKAY, v);
      axi_rd(8'h10, 32'h0, 32'hFFFFFFFF, `CFGL_RESP_SLVERR, v);
      axi_wr(8'h10, 32'h1, `CFGL_RESP_SLVERR);
      axi_wr(`CFGL_REG_STAT, 32'hFF, `CFGL_RESP_SLVERR);
      // divider clamps at both ends, then a random legal rate
      axi_wr(`CFGL_REG_DIV, 32'h0, `CFGL_RESP_OKAY);
      axi_rd(`CFGL_REG_DIV, 32'h1, 32'h1F, `CFGL_RESP_OKAY, v);
      axi_wr(`CFGL_REG_DIV, 32'h1F, `CFGL_RESP_OKAY);
      axi_rd(`CFGL_REG_DIV, 32'h19, 32'h1F, `CFGL_RESP_OKAY, v);
      d = 1 + ($unsigned($random(seed)) % 20);
      axi_wr(`CFGL_REG_DIV, 32'(d), `CFGL_RESP_OKAY);
      axi_rd(`CFGL_REG_DIV, 32'(d), 32'h1F, `CFGL_RESP_OKAY, v);
      // a divider write without its low byte lane leaves the rate alone
      wstrb <= 4'hE;
      axi_wr(`CFGL_REG_DIV, 32'h1F, `CFGL_RESP_OKAY);
      wstrb <= 4'hF;
      axi_rd(`CFGL_REG_DIV, 32'(d), 32'h1F, `CFGL_RESP_OKAY, v);
      load(1'b0);
      for (i = 0; i < 6; i++) chk(dev.rx_words[i], img[i + 1]);
      chk(32'(dev.dummy_cnt >= 49), 32'h1);
      chk(32'(user_io), 32'h1);
      chk(32'({sel_n, rst_oe}), 32'h3);
      axi_rd(`CFGL_REG_STAT, 32'hB0 | 32'(CFGL_LOADED), 32'h1FF, `CFGL_RESP_OKAY, v);
      // last mark stays pending and the data register keeps the final word
      axi_rd(`CFGL_REG_CTRL, 32'h2, 32'hFFFFFFFF, `CFGL_RESP_OKAY, v);
      axi_rd(`CFGL_REG_DATA, img[6], 32'hFFFFFFFF, `CFGL_RESP_OKAY, v);
      // restart with an image the device rejects: done stays low
      load(1'b1);
      axi_rd(`CFGL_REG_STAT, 32'h120 | 32'(CFGL_FAILED), 32'h1FF, `CFGL_RESP_OKAY, v);
      chk(32'(user_io), 32'h0);
      chk(32'(proto_err), 32'h0);
      give_verdict;
   end

   // watchdog well beyond the longest expected run
   initial begin
      #800000;
      err_count++;
      $display("ERROR %0t: watchdog expired", $time);
      give_verdict;
   end
endmodule
`default_nettype wire
